// ---- hdl/fpc_ctrl.sv ----
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module fpc_ctrl #(
    parameter int SUSP_WAIT = fpc_pkg::SUSP_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // flash pins
    output logic [fpc_pkg::ADDR_W-1:0] FL_ADDR,
    input wire logic [fpc_pkg::DATA_W-1:0] FL_DQ_IN,
    output logic [fpc_pkg::DATA_W-1:0] FL_DQ_OUT,
    output logic FL_DQ_OE,
    output logic FL_CE_N,
    output logic FL_WE_N,
    output logic FL_OE_N
);
    import fpc_pkg::*;

    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RSETUP, ST_RSAMPLE, ST_SUSPWAIT} fpc_state_t;

    fpc_state_t state, next_state;
    logic [3:0] cmd, next_cmd;              // active host command
    logic [ADDR_W-1:0] user_addr, next_user_addr;
    logic [DATA_W-1:0] user_data, next_user_data;
    logic [DATA_W-1:0] rd_data, next_rd_data; // last byte read from flash
    logic [2:0] step, next_step;            // bus cycle index in sequence
    logic [15:0] cnt, next_cnt;             // phase timer
    logic busy;
    logic [ADDR_W-1:0] cyc_addr;            // address of current cycle
    logic [DATA_W-1:0] cyc_data;            // data of current cycle
    logic [2:0] seq_len;
    logic [DATA_W-1:0] dq_s1, dq_s2;        // pin synchroniser

    // two flops on the data pins before any logic reads them
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= FL_DQ_IN;
            dq_s2 <= dq_s1;
        end
    end

    // unlock cycle: only the low eleven address bits carry meaning
    function automatic logic [ADDR_W-1:0] low_addr(input logic [10:0] a);
        low_addr = {{(ADDR_W-11){1'b0}}, a};
    endfunction : low_addr

    assign busy = (state != ST_IDLE);

    // sequence length per command
    always_comb begin
        case (cmd)
            CMD_PROG: seq_len = 3'd4;
            CMD_CHIP: seq_len = 3'd6;
            CMD_SECT: seq_len = 3'd6;
            CMD_IDENT: seq_len = 3'd3;
            // one write per queued sector keeps the gap far below the erase window
            CMD_ADDSECT: seq_len = 3'd1;
            default: seq_len = 3'd1;
        endcase
    end

    // address and data of each write cycle; single-cycle commands drive user_addr, the sector for CMD_ADDSECT
    always_comb begin
        cyc_addr = user_addr;
        cyc_data = user_data;
        case (cmd)
            CMD_PROG, CMD_CHIP, CMD_SECT, CMD_IDENT: begin
                case (step)
                    3'd0: begin
                        cyc_addr = low_addr(UNLOCK_A1);
                        cyc_data = BYTE_AA;
                    end
                    3'd3: begin
                        // fourth cycle: the target byte for a program, a second unlock for erases
                        cyc_addr = (cmd == CMD_PROG) ? user_addr : low_addr(UNLOCK_A1);
                        cyc_data = (cmd == CMD_PROG) ? user_data : BYTE_AA;
                    end
                    3'd1, 3'd4: begin
                        cyc_addr = low_addr(UNLOCK_A2);
                        cyc_data = BYTE_55;
                    end
                    3'd2: begin
                        cyc_addr = low_addr(UNLOCK_A1);
                        cyc_data = (cmd == CMD_PROG) ? BYTE_PROG : (cmd == CMD_IDENT) ? BYTE_IDENT : BYTE_SETUP;
                    end
                    default: begin
                        // final cycle of an erase: the sector with 30, or 555/10
                        cyc_addr = (cmd == CMD_CHIP) ? low_addr(UNLOCK_A1) : user_addr;
                        cyc_data = (cmd == CMD_CHIP) ? BYTE_CHIP : (cmd == CMD_SECT) ? BYTE_SECT : user_data;
                    end
                endcase
            end
            CMD_ADDSECT: cyc_data = BYTE_SECT;
            CMD_SUSP: cyc_data = BYTE_SUSP;
            CMD_RESUME: cyc_data = BYTE_SECT;
            CMD_RESET: cyc_data = BYTE_RESET;
            default: cyc_data = user_data;
        endcase
    end

    // bus sequencer and register file next state
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_user_addr = user_addr;
        next_user_data = user_data;
        next_rd_data = rd_data;
        next_step = step;
        next_cnt = cnt;
        if (cnt != 16'h0000) begin
            next_cnt = cnt - 16'h0001;
        end
        case (state)
            ST_IDLE: begin
                // writes land only while idle so a sequence is never torn
                if (AVS_WRITE) begin
                    case (AVS_ADDRESS)
                        REG_CTRL: begin
                            next_cmd = AVS_WRITEDATA[CTRL_CMD_LSB +: 4];
                            next_step = 3'd0;
                            if (AVS_WRITEDATA[CTRL_GO_BIT]) begin
                                next_cnt = 16'(PHASE_CYC);
                                next_state = (AVS_WRITEDATA[CTRL_CMD_LSB +: 4] == CMD_READ) ? ST_RSETUP : ST_SETUP;
                            end
                        end
                        REG_ADDR: next_user_addr = AVS_WRITEDATA[ADDR_W-1:0];
                        REG_DATA: next_user_data = AVS_WRITEDATA[DATA_W-1:0];
                        default: begin
                        end
                    endcase
                end
            end
            ST_SETUP: begin
                // address stable before the enables fall, so the later fall latches it
                if (cnt == 16'h0000) begin
                    next_cnt = 16'(PHASE_CYC);
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                // both enables low; their joint rise latches data
                if (cnt == 16'h0000) begin
                    next_cnt = 16'(PHASE_CYC);
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt == 16'h0000) begin
                    if (step == seq_len - 3'd1) begin
                        // last rise opens the erase window on the device side
                        next_cnt = 16'(SUSP_WAIT);
                        next_state = (cmd == CMD_SUSP) ? ST_SUSPWAIT : ST_IDLE;
                    end else begin
                        next_step = step + 3'd1;
                        next_cnt = 16'(PHASE_CYC);
                        next_state = ST_SETUP;
                    end
                end
            end
            ST_RSETUP: begin
                if (cnt == 16'h0000) begin
                    next_cnt = 16'(PHASE_CYC);
                    next_state = ST_RSAMPLE;
                end
            end
            ST_RSAMPLE: begin
                // wait for sync delay after output enable, then capture
                if (cnt == 16'h0000) begin
                    next_rd_data = dq_s2;
                    next_state = ST_IDLE;
                end
            end
            ST_SUSPWAIT: begin
                // suspend needs up to 30us before other sectors are usable
                if (cnt == 16'h0000) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            cmd <= CMD_READ;
            user_addr <= '0;
            user_data <= '0;
            rd_data <= '0;
            step <= 3'd0;
            cnt <= 16'h0000;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            user_addr <= next_user_addr;
            user_data <= next_user_data;
            rd_data <= next_rd_data;
            step <= next_step;
            cnt <= next_cnt;
        end
    end

    // pin outputs registered; enables and read address from next state, write address and data from the current cmd and step
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            FL_ADDR <= '0;
            FL_DQ_OUT <= '0;
            FL_DQ_OE <= 1'b0;
            FL_CE_N <= 1'b1;
            FL_WE_N <= 1'b1;
            FL_OE_N <= 1'b1;
        end else begin
            FL_ADDR <= (next_state == ST_RSETUP || next_state == ST_RSAMPLE) ? next_user_addr : cyc_addr;
            FL_DQ_OUT <= cyc_data;
            FL_DQ_OE <= (next_state == ST_SETUP || next_state == ST_STROBE || next_state == ST_HOLD);
            FL_CE_N <= !(next_state == ST_STROBE || next_state == ST_RSETUP || next_state == ST_RSAMPLE);
            FL_WE_N <= !(next_state == ST_STROBE);
            FL_OE_N <= !(next_state == ST_RSETUP || next_state == ST_RSAMPLE);
        end
    end

    // read mux; host polls status bits itself to find the end of an operation
    always_comb begin
        AVS_WAITREQUEST = 1'b0;
        AVS_READDATA = 32'h00000000;
        // data shows only while a read is held, zero otherwise
        if (AVS_READ) begin
            case (AVS_ADDRESS)
                REG_CTRL: AVS_READDATA = {27'h0000000, 1'b0, cmd};
                REG_ADDR: AVS_READDATA = {13'h0000, user_addr};
                REG_DATA: AVS_READDATA = {24'h000000, user_data};
                REG_STAT: AVS_READDATA = {23'h000000, busy, rd_data};
                default: AVS_READDATA = 32'h00000000;
            endcase
        end
    end
endmodule : fpc_ctrl

// ---- hdl/fpc_pkg.sv ----
package fpc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // host register offsets (byte addresses, word aligned)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // ctrl field positions
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_GO_BIT = 4;
    // host commands
    localparam logic [3:0] CMD_READ = 4'h0;
    localparam logic [3:0] CMD_PROG = 4'h1;
    localparam logic [3:0] CMD_CHIP = 4'h2;
    localparam logic [3:0] CMD_SECT = 4'h3;
    localparam logic [3:0] CMD_ADDSECT = 4'h4;
    localparam logic [3:0] CMD_SUSP = 4'h5;
    localparam logic [3:0] CMD_RESUME = 4'h6;
    localparam logic [3:0] CMD_RESET = 4'h7;
    localparam logic [3:0] CMD_IDENT = 4'h8;
    // flash command bytes and unlock addresses
    localparam logic [10:0] UNLOCK_A1 = 11'h555;
    localparam logic [10:0] UNLOCK_A2 = 11'h2AA;
    localparam logic [7:0] BYTE_AA = 8'hAA;
    localparam logic [7:0] BYTE_55 = 8'h55;
    localparam logic [7:0] BYTE_PROG = 8'hA0;
    localparam logic [7:0] BYTE_SETUP = 8'h80;
    localparam logic [7:0] BYTE_CHIP = 8'h10;
    localparam logic [7:0] BYTE_SECT = 8'h30;
    localparam logic [7:0] BYTE_SUSP = 8'hB0;
    localparam logic [7:0] BYTE_RESET = 8'hF0;
    localparam logic [7:0] BYTE_IDENT = 8'h90;
    // bus phase timing in cycles (4 ns each)
    localparam int CLK_MHZ = 250;
    localparam int PHASE_NS = 40;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int WINDOW_US = 50;
    localparam int SUSP_US = 30;
    localparam int SUSP_CYC = SUSP_US * CLK_MHZ;
    localparam int SEQ_MAX = 6;
endpackage : fpc_pkg

// ---- sim/fpc_checker.sv ----
`timescale 1ns/1ps
module fpc_checker #(
    parameter int SUSP_WAIT = fpc_pkg::SUSP_CYC // suspend busy span, unused by the checks
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    // flash pins
    input wire logic [fpc_pkg::ADDR_W-1:0] FL_ADDR,
    input wire logic [fpc_pkg::DATA_W-1:0] FL_DQ_OUT,
    input wire logic FL_DQ_OE,
    input wire logic FL_CE_N,
    input wire logic FL_WE_N,
    input wire logic FL_OE_N
);
    import fpc_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    // start order and its command code
    wire go = AVS_WRITE && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[CTRL_GO_BIT];
    wire [3:0] cmd = AVS_WRITEDATA[3:0];
    wire wp = !FL_WE_N; // write pulse on the pins
    a_we_needs_ce: assert property (wp |-> !FL_CE_N && FL_OE_N) else $error("pulse unselected");
    a_we_drives_dq: assert property (wp |-> FL_DQ_OE) else $error("pulse undriven");
    a_we_hold_bus: assert property (wp |=> FL_WE_N || ($stable(FL_ADDR) && $stable(FL_DQ_OUT)))
        else $error("bus moved in pulse");
    a_read_no_drive: assert property (!FL_OE_N |-> !FL_DQ_OE) else $error("bus contention");
    a_we_pulse_len: assert property ($fell(FL_WE_N) |-> wp[*8]) else $error("pulse short");
    a_prog_unlock: assert property (go && cmd == CMD_PROG |-> ##[1:60]
        (wp && FL_ADDR[10:0] == UNLOCK_A1 && FL_DQ_OUT == BYTE_AA)) else $error("no unlock");
    a_susp_byte: assert property (go && cmd == CMD_SUSP |-> ##[1:60] (wp && FL_DQ_OUT == BYTE_SUSP))
        else $error("no suspend byte");
    a_resume_byte: assert property (go && cmd == CMD_RESUME |-> ##[1:60] (wp && FL_DQ_OUT == BYTE_SECT))
        else $error("no resume byte");
    a_reset_byte: assert property (go && cmd == CMD_RESET |-> ##[1:60] (wp && FL_DQ_OUT == BYTE_RESET))
        else $error("no reset byte");
    c_chip: cover property (go && cmd == CMD_CHIP);
    c_sect: cover property (go && cmd == CMD_SECT);
    c_ident: cover property (go && cmd == CMD_IDENT);
endmodule : fpc_checker
bind fpc_ctrl fpc_checker #(.SUSP_WAIT(SUSP_WAIT)) i_chk (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .FL_ADDR(FL_ADDR), .FL_DQ_OUT(FL_DQ_OUT),
    .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N));

// ---- sim/fpc_flash_model.sv ----
`timescale 1ns/1ps
module fpc_flash_model #(
    parameter logic [7:0] MAKER_ID = 8'hC5 // arbitrary value
) (
    // flash pins
    input wire logic [18:0] addr,
    input wire logic [7:0] dq,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    output logic [7:0] q
);
    import fpc_pkg::*;
    logic [7:0] mem [0:31]; // four bytes per sector keep it small
    logic [7:0] wd; // last byte written
    logic [18:0] la = '0; // address taken at the later fall of select or write-enable
    bit susp = 1'b0; // a sector erase is suspended
    int st = 0; // command step
    wire wr = !ce_n && !we_n; // write pulse
    wire [4:0] ix = {addr[18:16], addr[1:0]};
    wire [4:0] wx = {la[18:16], la[1:0]};
    wire u1 = la[10:0] == UNLOCK_A1;
    wire u2 = la[10:0] == UNLOCK_A2;
    // a finished or dropped command falls back to suspend mode if an erase is parked
    wire [3:0] home = susp ? 4'd11 : 4'd0;
    wire [7:0] val = st == 9 ? MAKER_ID : mem[ix];
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // one sector back to ones; preprogramming is invisible here
    task automatic wipe(input logic [2:0] s);
        for (int i = 0; i < 4; i++) mem[{s, 2'(i)}] = 8'hFF;
    endtask : wipe
    // address taken when the pulse opens
    always @(posedge wr) la = addr;
    // byte taken at the earlier rise of select or write-enable
    always @(negedge wr) begin
        wd = dq;
        if (dq == BYTE_RESET && st != 3) st = home;
        else case (st)
            1: st = u2 && dq == BYTE_55 ? 2 : home;
            2: st = !u1 ? home : dq == BYTE_PROG ? 3 : dq == BYTE_SETUP ? 4 : dq == BYTE_IDENT ? 9 : home;
            3: begin
                // program ends at once here, so no command can land while it runs
                mem[wx] = mem[wx] & dq;
                st = home;
            end
            4: st = u1 && dq == BYTE_AA ? 5 : home;
            5: st = u2 && dq == BYTE_55 ? 6 : home;
            6: begin
                if (u1 && dq == BYTE_CHIP) foreach (mem[i]) mem[i] = 8'hFF;
                if (dq == BYTE_SECT) wipe(la[18:16]);
                st = dq == BYTE_SECT ? 10 : home;
            end
            9: st = 9; // identification held until reset
            10: begin
                if (dq == BYTE_SECT) wipe(la[18:16]);
                else begin
                    susp = dq == BYTE_SUSP;
                    st = susp ? 11 : 0;
                end
            end
            11: begin
                if (dq == BYTE_SECT) susp = 1'b0;
                st = dq == BYTE_SECT ? 10 : u1 && dq == BYTE_AA ? 1 : 11;
            end
            default: st = u1 && dq == BYTE_AA ? 1 : 0;
        endcase
    end
    // released bus shows the inverse so a stale byte never passes
    assign q = !ce_n && !oe_n ? val : ~val;
endmodule : fpc_flash_model

// ---- sim/test_fpc_ctrl.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, s); end end
module test_fpc_ctrl;
    import fpc_pkg::*;
    localparam logic [7:0] ID_BYTE = 8'hC5; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    // register bus
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wreq;
    // flash pins
    logic [ADDR_W-1:0] fa;
    logic [DATA_W-1:0] fi, fo;
    logic foe, ce_n, we_n, oe_n;
    logic [7:0] stat; // byte of the last finished read
    int bad_count = 0;
    int num_checks = 0;
    always #2 clk = ~clk;
    fpc_ctrl #(.SUSP_WAIT(20)) i_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .FL_ADDR(fa), .FL_DQ_IN(fi),
        .FL_DQ_OUT(fo), .FL_DQ_OE(foe), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n));
    fpc_flash_model #(.MAKER_ID(ID_BYTE)) i_mod (.addr(fa), .dq(fo), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .q(fi));
    // one register access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] r);
        @(posedge clk);
        adr <= a;
        wdat <= v;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        r = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc
    // load address and data, start, then poll until not busy
    task automatic op(input logic [3:0] c, input logic [18:0] a, input logic [7:0] d);
        logic [31:0] r;
        acc(1'b1, REG_ADDR, 32'(a), r);
        acc(1'b1, REG_DATA, 32'(d), r);
        acc(1'b1, REG_CTRL, 32'(c) | 32'h10, r);
        do acc(1'b0, REG_STAT, 32'h0, r); while (r[8] !== 1'b0);
        stat = r[7:0];
    endtask : op
    task automatic rchk(input logic [18:0] a, input logic [7:0] e);
        op(CMD_READ, a, 8'h00);
        `CHK("array byte", e, stat)
    endtask : rchk
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        logic [31:0] r;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b1, 4'h2, 32'hFF, r); // unmapped place is dropped
        op(CMD_PROG, 19'h00003, 8'h5A);
        rchk(19'h00003, 8'h5A);
        op(CMD_PROG, 19'h00003, 8'hF0);
        rchk(19'h00003, 8'h50);
        op(CMD_PROG, 19'h50001, 8'h0F);
        op(CMD_PROG, 19'h20002, 8'h00);
        rchk(19'h50001, 8'h0F);
        op(CMD_SECT, 19'h50000, 8'h00);
        rchk(19'h50001, 8'hFF);
        rchk(19'h20002, 8'h00);
        op(CMD_ADDSECT, 19'h20000, 8'h00);
        rchk(19'h20002, 8'hFF);
        op(CMD_SUSP, 19'h0, 8'h00);
        `CHK("suspend", BYTE_SUSP, i_mod.wd)
        op(CMD_PROG, 19'h70000, 8'h12);
        rchk(19'h70000, 8'h12);
        op(CMD_IDENT, 19'h0, 8'h00);
        rchk(19'h70001, ID_BYTE);
        op(CMD_RESET, 19'h0, 8'h00);
        op(CMD_RESUME, 19'h0, 8'h00);
        `CHK("resume", BYTE_SECT, i_mod.wd)
        op(CMD_RESET, 19'h0, 8'h00);
        `CHK("reset", BYTE_RESET, i_mod.wd)
        op(CMD_PROG, 19'h60000, 8'h00);
        op(CMD_ADDSECT, 19'h60000, 8'h00);
        rchk(19'h60000, 8'h00);
        op(CMD_IDENT, 19'h0, 8'h00);
        rchk(19'h00000, ID_BYTE);
        op(CMD_RESET, 19'h0, 8'h00);
        op(CMD_CHIP, 19'h0, 8'h00);
        rchk(19'h00003, 8'hFF);
        rchk(19'h70000, 8'hFF);
        results();
    end
    // tests need some 2000 cycles, so this only cuts a hang
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule : test_fpc_ctrl
